// ### mpr_pkg.sv
package mpr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [13:0] MPR_SEL_BASE   = 14'h0000;
  localparam logic [13:0] MPR_SEL_LAST   = 14'h003C;
  localparam logic [13:0] MPR_MAP_BASE   = 14'h2000;
  localparam logic [13:0] MPR_STATUS     = 14'h0040;
  localparam logic [13:0] MPR_STRAPS     = 14'h0044;
  localparam logic [13:0] MPR_WINDOW     = 14'h0048;

  // ----------------------------------------------------------------
  // Fields
  // ----------------------------------------------------------------
  localparam int MPR_SEL_VIDEO_BIT   = 5;
  localparam int MPR_SEL_FAULT_BIT   = 6;
  localparam int MPR_SEL_GATE_BIT    = 7;
  localparam int MPR_MAP_ENABLE_BIT  = 7;
  localparam int MPR_STATUS_FLAG_BIT = 7;
  localparam logic [15:0] MPR_VIDEO_LO = 16'h8000;
  localparam logic [15:0] MPR_VIDEO_HI = 16'hBFFF;
  localparam logic [7:0]  MPR_SEL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Debug strap encoding
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MPR_DBG_NONE,
    MPR_DBG_UNTIL_READ,
    MPR_DBG_NEVER
  } mpr_dbg_type;

  typedef enum logic [1:0] {
    MPR_PH_IDLE,
    MPR_PH_DATA
  } mpr_phase_type;

endpackage

// ### mpr_mem_if.sv
`timescale 1ns/100ps
interface mpr_mem_if;
  logic        wr;
  logic        rd;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [1:0]  block;
  logic        fault;
  logic        err;
  modport ctrl (output wr, rd, addr, wdata, block, fault, input rdata, err);
  modport mem  (input wr, rd, addr, wdata, block, fault, output rdata, err);
endinterface

// ### mpr_store.sv
`timescale 1ns/100ps
module mpr_store #(
  parameter int BLOCK_AW = 16
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Memory port.
  mpr_mem_if.mem   mem
);
  logic [8:0]  store [0:(4<<BLOCK_AW)-1];
  logic [BLOCK_AW+1:0] idx;
  logic [8:0]  word;
  logic [7:0]  rdata_reg;
  logic        err_reg;

  assign idx       = {mem.block, mem.addr[BLOCK_AW-1:0]};
  assign word      = store[idx];
  assign mem.rdata = rdata_reg;
  assign mem.err   = err_reg;

  always_ff @(posedge hclk) begin
    if (mem.wr) begin
      store[idx] <= {(^mem.wdata) ^ mem.fault, mem.wdata};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_reg <= 8'h00;
      err_reg   <= 1'b0;
    end else begin
      rdata_reg <= word[7:0];
      err_reg   <= mem.rd && ((^word[7:0]) != word[8]);
    end
  end
endmodule

// ### mpr_card.sv
`timescale 1ns/100ps
// Contract
// - Memory is four 64K blocks mapped in 2K or 4K pages.
// - Thirty-two independent translation sets exist, one active per cycle.
// - Active set follows bus owner, user/system line and DMA channel.
// - Nine-bit words: parity made on write, checked on read.
// - Parity mismatch on read raises an interrupt request.
// - Error captures flag, physical block and upper five address bits.
// - Reading parity status returns flag, block and low three captured address bits, then clears the flag.
// - Drive peripheral gate output; own selection and map writes obey returned gate.
// - Gate forced active after reset until first status read.
// - Video enable steers window 8000 to BFFF to graphics or RAM.
// - Test control forces parity errors.
// - 4K paging uses every other translation entry.
// - Two agreeing straps set page size; default is 2K.
// - Permanent debug strap never drives read data; writes still work.
// - Alternate debug strap blocks driver until first status read.
// - Board number from switches 1 to 3; fourth switch ignored.
// - Closed switch reads zero; switch 1 is the least significant bit.
// - Selection entry: inverted set, video, fault, gate bits.
// - Even map writes compare card number, qualified by page enable.
// - Odd map writes hold 64K block and 2K page.
// - Six states per processor; each DMA channel uses its own translation.
module mpr_card
  import mpr_pkg::*;
#(
  parameter int SETS = 32
) (
  // Clock and reset.
  input  wire  logic        hclk,
  input  wire  logic        hresetn,
  // AHB-Lite slave.
  input  wire  logic        hsel,
  input  wire  logic [31:0] haddr,
  input  wire  logic [1:0]  htrans,
  input  wire  logic        hwrite,
  input  wire  logic [2:0]  hsize,
  input  wire  logic [31:0] hwdata,
  input  wire  logic        hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  // Memory-side bus cycle.
  input  wire  logic        mem_req,
  input  wire  logic        mem_write,
  input  wire  logic [15:0] mem_addr,
  input  wire  logic [7:0]  mem_wdata,
  input  wire  logic        proc_owner,
  input  wire  logic        user_mode,
  input  wire  logic        dma_active,
  input  wire  logic [1:0]  dma_channel,
  output logic [7:0]        mem_rdata,
  output logic              mem_rdata_oe,
  output logic              mem_hit,
  output logic              video_window_enable,
  output logic              video_hit,
  // Backplane and pins.
  input  wire  logic        gate_return,
  input  wire  logic        page_size_strap_a,
  input  wire  logic        page_size_strap_b,
  input  wire  logic [1:0]  debug_driver_strap,
  input  wire  logic [3:0]  board_switch_n,
  output logic              peripheral_access_gate,
  output logic              parity_irq
);
  import mpr_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------
  logic [8:0] pin_s1_reg;
  logic [8:0] pin_s2_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_reg <= 9'h000;
      pin_s2_reg <= 9'h000;
    end else begin
      pin_s1_reg <= {gate_return, page_size_strap_a, page_size_strap_b,
                     debug_driver_strap, board_switch_n};
      pin_s2_reg <= pin_s1_reg;
    end
  end
  wire       gate_in_s  = pin_s2_reg[8];
  wire       page_4k    = pin_s2_reg[7] & pin_s2_reg[6];
  wire [1:0] dbg_s      = pin_s2_reg[5:4];
  wire [2:0] board_num  = pin_s2_reg[2:0];

  // ----------------------------------------------------------------
  // Tables.
  // ----------------------------------------------------------------
  logic [7:0] sel_table [0:15];
  logic [7:0] map_table [0:1023];
  logic [7:0] sel_out_reg;
  logic       card_select_flag_reg;
  logic       released_reg;
  logic       err_flag_reg;
  logic [1:0] err_block_reg;
  logic [4:0] err_addr_reg;

  // ----------------------------------------------------------------
  // Bus decode.
  // ----------------------------------------------------------------
  logic        ph_wr_reg;
  logic [13:0] ph_addr_reg;
  wire   take     = hsel & hready & htrans[1];
  wire   gate_ok  = ~gate_in_s;
  wire   is_sel   = ph_addr_reg < MPR_SEL_BASE + MPR_SEL_LAST + 14'h0004;
  wire   is_map   = ph_addr_reg >= MPR_MAP_BASE;
  wire   map_odd  = ph_addr_reg[2];
  wire [9:0] map_ix = ph_addr_reg[12:3];
  wire [7:0] wb     = hwdata[7:0];
  wire [3:0] sel_ix = ph_addr_reg[5:2];

  // ----------------------------------------------------------------
  // Read-back, decoded in the address phase.
  // ----------------------------------------------------------------
  wire [13:0] rb_addr = haddr[13:0];
  wire        rb_take = take & ~hwrite;
  wire        rb_sel  = rb_addr < MPR_SEL_BASE + MPR_SEL_LAST + 14'h0004;
  wire        rb_map  = rb_addr >= MPR_MAP_BASE;
  wire        rb_stat = rb_addr == MPR_STATUS;
  wire        stat_rd = rb_take & rb_stat;
  wire [7:0]  rb_byte = rb_stat ? {err_flag_reg, 2'b00, err_block_reg, err_addr_reg[2:0]}
                      : rb_sel ? sel_table[rb_addr[5:2]]
                      : rb_map ? map_table[rb_addr[12:3]]
                      : {2'b00, dbg_s, page_4k, board_num == 3'b000, 2'b00};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_reg   <= 1'b0;
      ph_addr_reg <= 14'h0000;
    end else begin
      ph_wr_reg   <= take & hwrite;
      ph_addr_reg <= haddr[13:0];
    end
  end

  always_ff @(posedge hclk) begin
    if (ph_wr_reg && gate_ok && is_sel) begin
      sel_table[sel_ix] <= wb;
    end
    if (ph_wr_reg && gate_ok && is_map && map_odd) begin
      map_table[map_ix] <= {card_select_flag_reg, wb[6:0]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      card_select_flag_reg <= 1'b0;
    end else if (ph_wr_reg && gate_ok && is_map && !map_odd) begin
      card_select_flag_reg <= wb[MPR_MAP_ENABLE_BIT] & (wb[2:0] == board_num);
    end
  end

  // ----------------------------------------------------------------
  // Translation.
  // ----------------------------------------------------------------
  wire [3:0] state_ix = {proc_owner, dma_active, dma_active ? dma_channel : {1'b0, user_mode}};
  wire [7:0] sel_word = sel_table[state_ix];
  wire [4:0] set_num  = ~sel_word[4:0];
  wire [4:0] page_ix  = page_4k ? {mem_addr[15:12], 1'b0} : mem_addr[15:11];
  wire [9:0] mp_ix    = {set_num, page_ix};
  wire [7:0] mp_word  = map_table[mp_ix];
  wire [4:0] phys_pg  = page_4k ? {mp_word[4:1], mem_addr[11]} : mp_word[4:0];
  wire [1:0] phys_blk = mp_word[6:5];
  wire       in_win   = (mem_addr >= MPR_VIDEO_LO) && (mem_addr <= MPR_VIDEO_HI);
  wire       vid_on   = ~sel_word[MPR_SEL_VIDEO_BIT];
  wire       hit      = mem_req & mp_word[7] & ~(in_win & vid_on);

  mpr_mem_if mif ();
  assign mif.wr    = hit & mem_write;
  assign mif.rd    = hit & ~mem_write;
  assign mif.addr  = {phys_pg, mem_addr[10:0]};
  assign mif.wdata = mem_wdata;
  assign mif.block = phys_blk;
  assign mif.fault = sel_word[MPR_SEL_FAULT_BIT];

  mpr_store u_store (
    .hclk    (hclk),
    .hresetn (hresetn),
    .mem     (mif.mem)
  );

  logic [1:0] rd_blk_reg;
  logic [4:0] rd_addr_reg;
  logic       rd_pend_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_blk_reg  <= 2'b00;
      rd_addr_reg <= 5'h00;
      rd_pend_reg <= 1'b0;
    end else begin
      rd_blk_reg  <= phys_blk;
      rd_addr_reg <= mem_addr[15:11];
      rd_pend_reg <= mif.rd;
    end
  end

  // ----------------------------------------------------------------
  // Error status and release.
  // ----------------------------------------------------------------
  wire par_err = rd_pend_reg & mif.err;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_flag_reg  <= 1'b0;
      err_block_reg <= 2'b00;
      err_addr_reg  <= 5'h00;
      released_reg  <= 1'b0;
    end else begin
      if (par_err) begin
        err_flag_reg  <= 1'b1;
        err_block_reg <= rd_blk_reg;
        err_addr_reg  <= rd_addr_reg;
      end else if (stat_rd) begin
        err_flag_reg  <= 1'b0;
      end
      if (stat_rd) begin
        released_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_out_reg <= MPR_SEL_RESET;
    end else begin
      sel_out_reg <= sel_word;
    end
  end

  wire drv_block = (dbg_s == MPR_DBG_NEVER) ||
                   ((dbg_s == MPR_DBG_UNTIL_READ) && !released_reg);

  // ----------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      peripheral_access_gate <= 1'b1;
      video_window_enable    <= 1'b1;
      parity_irq             <= 1'b0;
      mem_rdata              <= 8'h00;
      mem_rdata_oe           <= 1'b0;
      mem_hit                <= 1'b0;
      video_hit              <= 1'b0;
      hrdata                 <= 32'h0000_0000;
    end else begin
      peripheral_access_gate <= ~released_reg | ~sel_out_reg[MPR_SEL_GATE_BIT];
      video_window_enable    <= ~released_reg | vid_on;
      parity_irq             <= (err_flag_reg | par_err) & ~stat_rd;
      mem_rdata              <= mif.rdata;
      mem_rdata_oe           <= rd_pend_reg & ~drv_block;
      mem_hit                <= hit;
      video_hit              <= mem_req & in_win & vid_on;
      if (rb_take) begin
        hrdata <= {24'h00_0000, rb_byte};
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  property p_irq_hold;
    @(posedge hclk) disable iff (!hresetn) err_flag_reg && !stat_rd |=> parity_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped early");

  property p_clear;
    @(posedge hclk) disable iff (!hresetn) stat_rd && !par_err |=> !err_flag_reg;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");

  property p_gate;
    @(posedge hclk) disable iff (!hresetn) !released_reg |=> peripheral_access_gate;
  endproperty
  a_gate: assert property (p_gate) else $error("gate not forced");

  property p_never;
    @(posedge hclk) disable iff (!hresetn) dbg_s == MPR_DBG_NEVER |=> !mem_rdata_oe;
  endproperty
  a_never: assert property (p_never) else $error("driver enabled");

  property p_irq_set;
    @(posedge hclk) disable iff (!hresetn) par_err && !stat_rd |=> parity_irq;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("irq not raised");

  property p_capture;
    @(posedge hclk) disable iff (!hresetn)
      par_err |=> err_flag_reg && (err_block_reg == $past(rd_blk_reg));
  endproperty
  a_capture: assert property (p_capture) else $error("error not captured");

  property p_video;
    @(posedge hclk) disable iff (!hresetn) !released_reg |=> video_window_enable;
  endproperty
  a_video: assert property (p_video) else $error("video not forced");
endmodule

// ### mpr_bus_model.sv
`timescale 1ns/100ps
module mpr_bus_model (
  // Clock.
  input  wire logic        hclk,
  // Bus cycle toward the card.
  output logic             mem_req,
  output logic             mem_write,
  output logic [15:0]      mem_addr,
  output logic [7:0]       mem_wdata,
  output logic             proc_owner,
  output logic             user_mode,
  output logic             dma_active,
  output logic [1:0]       dma_channel,
  output logic             gate_return,
  // Answer from the card.
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        mem_rdata_oe,
  input  wire logic        mem_hit
);
  initial begin
    {mem_req, mem_write, mem_addr, mem_wdata} = '0;
    {proc_owner, user_mode, dma_active, dma_channel, gate_return} = '0;
  end

  // One memory cycle; the bus shows the inverse once released.
  task automatic cycle(input logic wr, input logic [15:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic oe, output logic h);
    @(posedge hclk);
    mem_req   <= 1'b1;
    mem_write <= wr;
    mem_addr  <= a;
    mem_wdata <= d;
    @(posedge hclk);
    mem_req   <= 1'b0;
    mem_addr  <= ~a;
    mem_wdata <= ~d;
    #1;
    h = mem_hit;
    @(posedge hclk);
    #1;
    q  = mem_rdata;
    oe = mem_rdata_oe;
  endtask

  // Machine state: owner, user line, DMA flag and channel.
  task automatic set_state(input logic [4:0] s);
    @(posedge hclk);
    {proc_owner, user_mode, dma_active, dma_channel} <= s;
  endtask

  // Backplane return of the peripheral gate.
  task automatic set_gate(input logic v);
    @(posedge hclk);
    gate_return <= v;
    repeat (3) @(posedge hclk);
  endtask
endmodule

// ### tb.sv
`timescale 1ns/100ps
module tb;
  import mpr_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0]  htrans = 0, debug_driver_strap = 0, dma_channel;
  logic [2:0]  hsize = 3'b010;
  logic mem_req, mem_write, proc_owner, user_mode, dma_active, gate_return, oe;
  logic [15:0] mem_addr;
  logic [7:0]  mem_wdata, mem_rdata, q;
  logic mem_rdata_oe, mem_hit, video_window_enable, video_hit, h;
  logic peripheral_access_gate, parity_irq;
  int mismatches = 0, checked = 0;
  localparam logic [31:0] SEL = {18'h0_0000, MPR_SEL_BASE};
  localparam logic [31:0] MAP = {18'h0_0000, MPR_MAP_BASE};
  localparam logic [31:0] STA = {18'h0_0000, MPR_STATUS};
  localparam logic [31:0] STR = {18'h0_0000, MPR_STRAPS};

  initial begin
    forever #50 hclk = ~hclk;
  end

  mpr_card uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .proc_owner(proc_owner), .user_mode(user_mode),
    .dma_active(dma_active), .dma_channel(dma_channel), .mem_rdata(mem_rdata),
    .mem_rdata_oe(mem_rdata_oe), .mem_hit(mem_hit),
    .video_window_enable(video_window_enable), .video_hit(video_hit),
    .gate_return(gate_return), .page_size_strap_a(1'b0), .page_size_strap_b(1'b0),
    .debug_driver_strap(debug_driver_strap), .board_switch_n(4'b1010),
    .peripheral_access_gate(peripheral_access_gate), .parity_irq(parity_irq));

  mpr_bus_model bus (.hclk(hclk), .mem_req(mem_req), .mem_write(mem_write),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .proc_owner(proc_owner),
    .user_mode(user_mode), .dma_active(dma_active), .dma_channel(dma_channel),
    .gate_return(gate_return), .mem_rdata(mem_rdata), .mem_rdata_oe(mem_rdata_oe),
    .mem_hit(mem_hit));

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0000_0000, "response");
  endtask

  task automatic map(input logic [7:0] even, input logic [7:0] odd);
    ahb(1'b1, MAP + 32'h0000_0010, {24'h00_0000, even});
    ahb(1'b1, MAP + 32'h0000_0014, {24'h00_0000, odd});
  endtask

  task automatic init(input logic [1:0] dbg, input logic [7:0] sel);
    hresetn <= 1'b0;
    debug_driver_strap <= dbg;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    chk({30'h0, peripheral_access_gate, video_window_enable}, 32'h0000_0003, "forced");
    for (int i = 0; i < 16; i++) ahb(1'b1, SEL + 4 * i, {24'h00_0000, sel});
    map(8'h82, 8'h45);
  endtask

  task automatic rd_chk(input logic [7:0] exp, input logic exp_oe, input logic exp_hit);
    bus.cycle(1'b0, 16'h1000, 8'h00, q, oe, h);
    if (exp_oe) chk({24'h00_0000, q}, {24'h00_0000, exp}, "read data");
    chk({30'h0, oe, h}, {30'h0, exp_oe, exp_hit}, "oe and hit");
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    test_done();
  end

  initial begin
    init(2'd0, 8'hBF);
    chk({31'h0, parity_irq}, 32'h0000_0000, "irq after reset");
    bus.cycle(1'b1, 16'h1000, 8'hA5, q, oe, h);
    rd_chk(8'hA5, 1'b1, 1'b1);
    chk({30'h0, peripheral_access_gate, video_window_enable}, 32'h0000_0003, "held");
    ahb(1'b0, STA, 32'h0000_0000);
    chk(rd & 32'h0000_0080, 32'h0000_0000, "clean status");
    rd_chk(8'hA5, 1'b1, 1'b1);
    chk({30'h0, peripheral_access_gate, video_window_enable}, 32'h0000_0000, "released");
    map(8'h83, 8'h45);
    rd_chk(8'hA5, 1'b0, 1'b0);
    map(8'h02, 8'h45);
    rd_chk(8'hA5, 1'b0, 1'b0);
    map(8'h82, 8'h45);
    for (int s = 0; s < 32; s++) begin
      bus.set_state(5'(s));
      rd_chk(8'hA5, 1'b1, 1'b1);
    end
    init(2'd0, 8'h5F);
    bus.set_gate(1'b1);
    map(8'h82, 8'h65);
    bus.set_gate(1'b0);
    bus.cycle(1'b1, 16'h1000, 8'h3C, q, oe, h);
    bus.cycle(1'b0, 16'h1000, 8'h00, q, oe, h);
    repeat (4) @(posedge hclk);
    chk({31'h0, parity_irq}, 32'h0000_0001, "irq raised");
    repeat (5) @(posedge hclk);
    chk({31'h0, parity_irq}, 32'h0000_0001, "irq held");
    ahb(1'b0, STA, 32'h0000_0000);
    chk(rd & 32'h0000_00FF, 32'h0000_0092, "captured status");
    repeat (2) @(posedge hclk);
    chk({31'h0, parity_irq}, 32'h0000_0000, "irq released");
    ahb(1'b0, STA, 32'h0000_0000);
    chk(rd & 32'h0000_0080, 32'h0000_0000, "flag cleared");
    ahb(1'b0, STR, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "straps");
    for (int d = 1; d < 3; d++) begin
      init(2'(d), 8'h1F);
      bus.cycle(1'b1, 16'h1000, 8'h5A, q, oe, h);
      rd_chk(8'h5A, 1'b0, 1'b1);
      ahb(1'b0, STA, 32'h0000_0000);
      rd_chk(8'h5A, d == 1, 1'b1);
    end
    test_done();
  end
endmodule
